// file: lsl_shift_latch.sv
// Serial shift register, gray-level, control and correction latches of a 48-channel LED sink driver.
`timescale 1ns/1ns

`include "lsl_map.svh"

module lsl_shift_latch
	import lsl_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         shiftClk,
	input  wire logic         serialIn,
	input  wire logic         loadStrobe,
	output logic              serialOut,
	output lsl_gray_t         grayLevel,
	output lsl_ctrl_t         controlData,
	output lsl_trim_t         trimLevel,
	output logic              outputsEnabled,
	output lsl_current_t      channelCurrent
);

	// Shift register, strobe synchroniser and latch state.
	logic [`LSL_SR_W-1:0] shiftReg_r;
	logic                 strobeMeta_r;
	logic                 strobeSync_r;
	logic                 strobeLast_r;
	logic                 strobeRise;
	logic                 topBit;
	logic                 headerOk;
	lsl_gray_t            grayLevel_r;
	lsl_ctrl_t            controlData_r;
	lsl_trim_t            trimLevel_r;
	logic                 outputsEnabled_r;
	lsl_current_t         channelCurrent_r;
	lsl_gain_t            groupGain;

	// The shift register runs on the link clock and has no reset, as the real
	// part powers up with random content; serialOut is unknown until filled.
	// Only the link clock moves these bits; the system clock never writes them.
	always_ff @(posedge shiftClk) begin
		shiftReg_r <= {shiftReg_r[`LSL_SR_W-2:0], serialIn};
	end

	// The top bit is a flip-flop, so the cascade output needs no extra stage.
	assign serialOut = shiftReg_r[`LSL_TOP_BIT];

	// The load strobe is brought into the system clock through two flip-flops.
	// The third flop only remembers the last level for the rising-edge detector.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strobeMeta_r <= `LSL_SYNC_ZERO;
			strobeSync_r <= `LSL_SYNC_ZERO;
			strobeLast_r <= `LSL_SYNC_ZERO;
		end else begin
			strobeMeta_r <= loadStrobe;
			strobeSync_r <= strobeMeta_r;
			strobeLast_r <= strobeSync_r;
		end
	end

	// The shift register is read across domains only while the controller holds
	// the shift clock still around the strobe, so its bits are quasi-static here.
	// A controller that shifts inside that window breaks this, and a latch would
	// then capture a mix of old and new bits.
	assign strobeRise = strobeSync_r & ~strobeLast_r;
	assign topBit     = shiftReg_r[`LSL_TOP_BIT];
	assign headerOk   = (shiftReg_r[`LSL_HDR_HI:`LSL_HDR_LO] == `LSL_HDR_VALUE);

	// Gray-level latch; the trim latch follows the control latch on each gray write.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			grayLevel_r <= '0;
			trimLevel_r <= '0;
		end else if (strobeRise && !topBit) begin
			grayLevel_r <= shiftReg_r[`LSL_GS_W-1:0];
			trimLevel_r <= controlData_r[`LSL_TRIM_W-1:0];
		end
	end

	// Control latch; a bad header falls through and leaves everything as it was.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			controlData_r <= '0;
		end else if (strobeRise && topBit && headerOk) begin
			controlData_r <= shiftReg_r[`LSL_CTRL_W-1:0];
		end
	end

	// Channels are held off from reset until the first gray-level write.
	// A reset in mid-run clears it again, so the channels stay dark until the next gray write.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			outputsEnabled_r <= `LSL_SYNC_ZERO;
		end else if (strobeRise && !topBit) begin
			outputsEnabled_r <= 1'b1;
		end
	end

	// The three group gains sit above the trim field; red takes the lowest seven bits.
	assign groupGain = lsl_gain_t'(controlData_r[`LSL_GAIN_LSB +: `LSL_GAIN_W]);

	// Each channel's current as a fraction of LSL_CURR_FULL, which stands for the
	// group full current; the product stays exact integer to avoid rounding drift.
	genvar ch;
	generate
		for (ch = 0; ch < `LSL_CH; ch++) begin : gChan
			logic [`LSL_TRIM_BITS-1:0] gainCode;
			logic [31:0]               trimFactor;
			logic [31:0]               gainFactor;
			logic [63:0]               product;

			// Channel colours repeat red, green, blue, so the group is the index modulo three.
			assign gainCode   = (ch % 3 == 0) ? groupGain.red : ((ch % 3 == 1) ? groupGain.green : groupGain.blue);
			assign trimFactor = `LSL_TRIM_BASE + `LSL_TRIM_STEP * {25'h0, trimLevel_r[ch]};
			assign gainFactor = `LSL_GAIN_BASE + `LSL_GAIN_STEP * {25'h0, gainCode};
			assign product    = trimFactor * gainFactor;

			// Registered so that the current word leaves the block from a clean flop.
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					channelCurrent_r[ch] <= '0;
				end else begin
					channelCurrent_r[ch] <= product[31:0];
				end
			end

			// Both codes at maximum must yield exactly the full group current.
			a_full_current: assert property (@(posedge clk) disable iff (!rst_n)
				(trimLevel_r[ch] == `LSL_CODE_MAX && gainCode == `LSL_CODE_MAX)
				|=> (channelCurrent_r[ch] == `LSL_CURR_FULL))
				else $error("full codes did not give full current");

			// Both codes at zero give the floor of both factors.
			a_base_current: assert property (@(posedge clk) disable iff (!rst_n)
				(rst_n && trimLevel_r[ch] == '0 && gainCode == '0)
				|=> (channelCurrent_r[ch] == `LSL_CURR_BASE))
				else $error("zero codes did not give the base current");
		end
	endgenerate

	// Every output is taken straight from its latch flop, so no logic sits on a pin.
	assign grayLevel      = grayLevel_r;
	assign controlData    = controlData_r;
	assign trimLevel      = trimLevel_r;
	assign outputsEnabled = outputsEnabled_r;
	assign channelCurrent = channelCurrent_r;

	// New serial bit lands in bit 0 on each shift edge.
	a_shift_entry: assert property (@(posedge shiftClk) disable iff (!rst_n)
		1'b1 |=> (shiftReg_r[0] == $past(serialIn)))
		else $error("serial bit not loaded into bit 0");

	// Every bit moves one place toward the top; random power-up bits move along unchanged.
	a_shift_move: assert property (@(posedge shiftClk) disable iff (!rst_n)
		1'b1 |=> (shiftReg_r[`LSL_SR_W-1:1] === $past(shiftReg_r[`LSL_SR_W-2:0])))
		else $error("shift register did not move up");

	// The cascade output shows the bit that was one below the top an edge ago.
	a_serial_out: assert property (@(posedge shiftClk) disable iff (!rst_n)
		1'b1 |=> (serialOut === $past(shiftReg_r[`LSL_TOP_BIT-1])))
		else $error("serial output not the top bit");

	// A gray write copies the lower 768 bits.
	a_gray_load: assert property (@(posedge clk) disable iff (!rst_n)
		(strobeRise && !topBit) |=> (grayLevel_r == $past(shiftReg_r[`LSL_GS_W-1:0])))
		else $error("gray latch not loaded");

	// A valid control write copies the lower 371 bits and spares the gray latch.
	a_ctrl_load: assert property (@(posedge clk) disable iff (!rst_n)
		(strobeRise && topBit && headerOk)
		|=> (controlData_r == $past(shiftReg_r[`LSL_CTRL_W-1:0])) && $stable(grayLevel_r))
		else $error("control latch not loaded");

	// A wrong header changes neither latch.
	a_bad_header: assert property (@(posedge clk) disable iff (!rst_n)
		(strobeRise && topBit && !headerOk) |=> ($stable(controlData_r) && $stable(grayLevel_r)))
		else $error("latch changed on bad header");

	// Outputs come on only right after a gray write.
	a_off_until: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(outputsEnabled_r) |-> $past(strobeRise && !topBit))
		else $error("outputs enabled without gray write");

	// The trim latch takes the control latch's low bits at a gray write.
	a_trim_copy: assert property (@(posedge clk) disable iff (!rst_n)
		(strobeRise && !topBit) |=> (trimLevel_r == $past(controlData_r[`LSL_TRIM_W-1:0])))
		else $error("trim latch not refreshed");

	// Only a gray write may change the gray latch.
	a_gray_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!(strobeRise && !topBit) |=> $stable(grayLevel_r))
		else $error("gray latch changed without a gray write");

	// Only a valid control write may change the control latch.
	a_ctrl_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!(strobeRise && topBit && headerOk) |=> $stable(controlData_r))
		else $error("control latch changed without a control write");

	// The trim latch changes only at a gray write.
	a_trim_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!(strobeRise && !topBit) |=> $stable(trimLevel_r))
		else $error("trim latch changed without a gray write");

	// Once on, the channels stay enabled until the next reset.
	a_enable_hold: assert property (@(posedge clk) disable iff (!rst_n)
		outputsEnabled_r |=> outputsEnabled_r)
		else $error("outputs turned off without reset");

endmodule

// file: lsl_map.svh
// Constants of the LED driver shift register and data latches.
`ifndef LSL_MAP_SVH
`define LSL_MAP_SVH

`define LSL_SR_W        769
`define LSL_TOP_BIT     768
`define LSL_GS_W        768
`define LSL_CTRL_W      371
`define LSL_TRIM_W      336
`define LSL_CH          48
`define LSL_LEVEL_W     16
`define LSL_TRIM_BITS   7
`define LSL_HDR_HI      767
`define LSL_HDR_LO      760
`define LSL_HDR_VALUE   8'h96
`define LSL_GAIN_LSB    345
`define LSL_GAIN_W      21
`define LSL_TRIM_BASE   32'h000081fa
`define LSL_TRIM_STEP   32'h000002e2
`define LSL_GAIN_BASE   32'h000004f6
`define LSL_GAIN_STEP   32'h0000005a
`define LSL_CURR_FULL   32'h6022e6a0
`define LSL_CURR_BASE   32'h0284ce3c
`define LSL_CODE_MAX    7'h7f
`define LSL_SYNC_ZERO   1'b0

`endif

// file: lsl_pkg.sv
// Types shared by the LED driver shift and latch logic.
`include "lsl_map.svh"

package lsl_pkg;

	typedef logic [`LSL_CH-1:0][`LSL_LEVEL_W-1:0] lsl_gray_t;
	typedef logic [`LSL_CH-1:0][`LSL_TRIM_BITS-1:0] lsl_trim_t;
	typedef logic [`LSL_CTRL_W-1:0] lsl_ctrl_t;
	typedef logic [`LSL_CH-1:0][31:0] lsl_current_t;

	typedef struct packed {
		logic [`LSL_TRIM_BITS-1:0] blue;
		logic [`LSL_TRIM_BITS-1:0] green;
		logic [`LSL_TRIM_BITS-1:0] red;
	} lsl_gain_t;

endpackage

// file: lsl_ctrl_model.sv
// Display controller model that shifts frames in and raises the load strobe.
`timescale 1ns/1ns

module lsl_ctrl_model (
	input  wire logic clk,
	output logic      shiftClk,
	output logic      serialIn,
	output logic      loadStrobe
);
	// Idle levels at time zero, before any frame is sent.
	initial begin
		shiftClk = 1'b0;
		serialIn = 1'b0;
		loadStrobe = 1'b0;
	end

	// The shift clock runs only inside a frame, at 30 ns, top bit first.
	task automatic send_frame(input logic [768:0] f);
		#7;
		for (int i = 768; i >= 0; i--) begin
			serialIn = f[i];
			#15 shiftClk = 1'b1;
			#15 shiftClk = 1'b0;
		end
		// A released data line shows the inverse of its last bit, so stale data cannot pass.
		serialIn = ~f[0];
		repeat (2) @(posedge clk);
		loadStrobe <= 1'b1;
		repeat (6) @(posedge clk);
		loadStrobe <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
endmodule

// file: lsl_shift_latch_tb_top.sv
// Self-checking bench of the LED driver shift register and latches.
`timescale 1ns/1ns
`include "lsl_map.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; $display("[FAIL] %0t mismatch", $time); end end

module lsl_shift_latch_tb_top import lsl_pkg::*;;
	typedef struct packed {
		logic [767:0] g;
		logic [370:0] c;
		logic [335:0] t;
		logic         e;
		logic         s;
	} lsl_note_t;
	logic         clk, rst_n, shiftClk, serialIn, loadStrobe, serialOut, outputsEnabled;
	lsl_gray_t    grayLevel;
	lsl_ctrl_t    controlData;
	lsl_trim_t    trimLevel;
	lsl_current_t channelCurrent;
	int           fail_count = 0;
	int           n_checks = 0;
	lsl_note_t    q[$];
	lsl_note_t    md, got;
	logic [15:0]  seed = 16'h004b;
	logic [768:0] f;
	logic [31:0]  want;

	// Free-running 20 MHz system clock.
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	lsl_shift_latch lsl_shift_latch_i (.clk(clk), .rst_n(rst_n), .shiftClk(shiftClk), .serialIn(serialIn),
		.loadStrobe(loadStrobe), .serialOut(serialOut), .grayLevel(grayLevel), .controlData(controlData),
		.trimLevel(trimLevel), .outputsEnabled(outputsEnabled), .channelCurrent(channelCurrent));
	lsl_ctrl_model lsl_ctrl_model_i (.clk(clk), .shiftClk(shiftClk), .serialIn(serialIn), .loadStrobe(loadStrobe));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Expected current word from one trim code and one group gain code.
	function automatic logic [31:0] expCurrent(input logic [6:0] trim, input logic [6:0] gain);
		return (`LSL_TRIM_BASE + `LSL_TRIM_STEP * trim) * (`LSL_GAIN_BASE + `LSL_GAIN_STEP * gain);
	endfunction

	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// The monitor compares the oldest note once the latches have settled.
	initial forever begin
		wait (q.size() > 0);
		@(posedge clk);
		#1 got = q.pop_front();
		`CHK(grayLevel, got.g)
		`CHK(controlData, got.c)
		`CHK(trimLevel, got.t)
		`CHK(outputsEnabled, got.e)
		for (int c = 0; c < `LSL_CH; c++) begin
			want = expCurrent(got.t[7*c +: 7], got.c[`LSL_GAIN_LSB + 7*(c % 3) +: 7]);
			`CHK(channelCurrent[c], want)
		end
		`CHK(serialOut, got.s)
	end

	// Frames: bad header, control, gray, all-ones control, gray, then a mid-run reset.
	initial begin
		rst_n = 1'b0;
		md = '0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int k = 0; k < 6; k++) begin
			if (k == 5) begin
				// A reset in mid-run clears every latch and darkens the channels; serialOut keeps its bit.
				rst_n <= 1'b0;
				repeat (4) @(posedge clk);
				rst_n <= 1'b1;
				@(posedge clk);
				md.g = '0;
				md.c = '0;
				md.t = '0;
				md.e = 1'b0;
			end else begin
				for (int b = 0; b < 769; b++) begin
					seed = lfsr(seed);
					f[b] = (k == 3) ? 1'b1 : seed[0]; // Full gains keep the group current well above the floor.
				end
				f[768] = (k == 0 || k == 1 || k == 3);
				if (f[768]) f[767:760] = (k == 0) ? 8'h95 : 8'h96;
				lsl_ctrl_model_i.send_frame(f);
				if (!f[768]) begin
					md.g = f[767:0];
					md.t = md.c[335:0];
					md.e = 1'b1;
				end else if (f[767:760] == 8'h96) begin
					md.c = f[370:0];
				end
			end
			md.s = f[768];
			q.push_back(md);
			wait (q.size() == 0);
			$display("Test %0d done", k);
		end
		repeat (4) @(posedge clk);
		stop_test();
	end

	// Five frames and a reset take about 2400 cycles; far beyond that means a hang.
	initial begin
		#1200000;
		fail_count++;
		stop_test();
	end
endmodule
